// ---- bench/rtcai_host.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host side of the shared interrupt line
// ----------------------------------------------------------------
module rtcai_host (
    // Open-drain driver of the device
    input wire logic i_irq_n_out,
    input wire logic i_irq_n_oe,
    // Level that the host pin sees
    output logic o_irq_pin_n
);
    // The board pull-up wins whenever the device lets go of the line.
    assign o_irq_pin_n = i_irq_n_oe ? i_irq_n_out : 1'b1;
endmodule : rtcai_host

// ---- bench/test_rtc_alarm_update_interrupt.sv ----
`timescale 1ns/10ps
module test_rtc_alarm_update_interrupt;
    import rtcai_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int P_CYC = 20; // Short pulse keeps the run brief.
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    rtcai_time_t i_time = '0;
    logic i_sec_tick = 1'b0;
    logic i_min_tick = 1'b0;
    rtcai_bus_t i_bus = '0;
    logic [7:0] o_rdata;
    logic o_irq_n_out;
    logic o_irq_n_oe;
    logic o_irq;
    logic pin_n;
    logic [7:0] addrs [9] = '{8'h17, 8'h18, 8'h19, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h30};
    int error_cnt = 0;
    int comparisons = 0;
    int n;

    always #2 i_clk_sys = ~i_clk_sys;

    rtcai_core #(.P_PULSE_CYC(P_CYC)) uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_time(i_time),
        .i_sec_tick(i_sec_tick), .i_min_tick(i_min_tick), .i_bus(i_bus), .o_rdata(o_rdata),
        .o_irq_n_out(o_irq_n_out), .o_irq_n_oe(o_irq_n_oe), .o_irq(o_irq));
    rtcai_host host (.i_irq_n_out(o_irq_n_out), .i_irq_n_oe(o_irq_n_oe), .o_irq_pin_n(pin_n));

    // ----------------------------------------------------------------
    // Compare, bus and event tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk_sys);
        i_bus <= '0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk_sys);
        i_bus <= '0;
        #1;
        chk_byte(o_rdata, exp);
    endtask : rd_chk

    task automatic tick(input logic minute);
        @(posedge i_clk_sys);
        i_min_tick <= minute;
        i_sec_tick <= ~minute;
        @(posedge i_clk_sys);
        i_min_tick <= 1'b0;
        i_sec_tick <= 1'b0;
        #1;
    endtask : tick

    task automatic settle();
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask : settle

    // Clear all flags, present a time at the minute boundary, then look.
    task automatic alarm_try(input rtcai_time_t t, input logic flag, input logic drive);
        bus_wr(ADDR_EVENT_FLAGS, 8'h00);
        i_time <= t;
        tick(1'b1);
        chk_bit(pin_n, ~drive);
        rd_chk(ADDR_EVENT_FLAGS, {4'h0, flag, 3'h0});
    endtask : alarm_try

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        foreach (addrs[k]) begin
            rd_chk(addrs[k], 8'h00);
        end
        bus_wr(ADDR_ALARM_MINUTE, 8'hA5);
        rd_chk(ADDR_ALARM_MINUTE, 8'hA5);
        bus_wr(ADDR_EVENT_FLAGS, 8'hFF);
        rd_chk(ADDR_EVENT_FLAGS, 8'h00);
        // Second update with the line enabled: exact pulse, sticky flag.
        bus_wr(ADDR_IRQ_MASK, 8'h03);
        bus_wr(ADDR_IRQ_CONTROL, 8'h20);
        tick(1'b0);
        n = 0;
        while (pin_n === 1'b0 && n < 200) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            summarize();
        end
        chk_byte(8'(n), 8'(P_CYC));
        rd_chk(ADDR_EVENT_FLAGS, 8'h20);
        chk_bit(o_irq, 1'b1);
        bus_wr(ADDR_IRQ_STATUS, 8'h01);
        settle();
        chk_bit(o_irq, 1'b0);
        // A minute tick counts only once minute select is on.
        bus_wr(ADDR_EVENT_FLAGS, 8'h00);
        tick(1'b1);
        chk_bit(pin_n, 1'b1);
        bus_wr(ADDR_EXT_CONTROL, 8'h20);
        tick(1'b1);
        chk_bit(pin_n, 1'b0);
        bus_wr(ADDR_EVENT_FLAGS, 8'h00);
        chk_bit(pin_n, 1'b0);
        bus_wr(ADDR_IRQ_CONTROL, 8'h00);
        @(posedge i_clk_sys);
        #1;
        chk_bit(pin_n, 1'b1);
        tick(1'b1);
        chk_bit(pin_n, 1'b1);
        rd_chk(ADDR_EVENT_FLAGS, 8'h20);
        // Alarm setup with the alarm enable held off meanwhile.
        bus_wr(ADDR_EXT_CONTROL, 8'h00);
        bus_wr(ADDR_IRQ_STATUS, 8'h03);
        bus_wr(ADDR_ALARM_MINUTE, 8'h30);
        bus_wr(ADDR_ALARM_HOUR, 8'h12);
        bus_wr(ADDR_ALARM_WDAY_DATE, 8'h2A);
        bus_wr(ADDR_IRQ_CONTROL, 8'h08);
        for (int k = 0; k < 7; k++) begin
            alarm_try('{7'h30, 6'h12, 3'(k), 6'h01}, k[0], k[0] && k != 0);
        end
        alarm_try('{7'h30, 6'h13, 3'd1, 6'h01}, 1'b0, 1'b0);
        alarm_try('{7'h31, 6'h12, 3'd5, 6'h01}, 1'b0, 1'b0);
        alarm_try('{7'h30, 6'h12, 3'd5, 6'h01}, 1'b1, 1'b1);
        repeat (3 * P_CYC) @(posedge i_clk_sys);
        #1;
        chk_bit(pin_n, 1'b0);
        rd_chk(ADDR_IRQ_STATUS, 8'h02);
        bus_wr(ADDR_IRQ_MASK, 8'h01);
        settle();
        chk_bit(o_irq, 1'b0);
        bus_wr(ADDR_IRQ_MASK, 8'h03);
        settle();
        chk_bit(o_irq, 1'b1);
        bus_wr(ADDR_IRQ_STATUS, 8'h02);
        settle();
        chk_bit(o_irq, 1'b0);
        bus_wr(ADDR_EVENT_FLAGS, 8'h08);
        rd_chk(ADDR_EVENT_FLAGS, 8'h08);
        chk_bit(pin_n, 1'b0);
        bus_wr(ADDR_EVENT_FLAGS, 8'h00);
        @(posedge i_clk_sys);
        #1;
        chk_bit(pin_n, 1'b1);
        // Day masked, then date mode, then every field masked.
        bus_wr(ADDR_IRQ_CONTROL, 8'h00);
        bus_wr(ADDR_ALARM_WDAY_DATE, 8'h80);
        bus_wr(ADDR_IRQ_CONTROL, 8'h08);
        alarm_try('{7'h30, 6'h12, 3'd0, 6'h01}, 1'b1, 1'b1);
        bus_wr(ADDR_IRQ_CONTROL, 8'h00);
        bus_wr(ADDR_EXT_CONTROL, 8'h08);
        bus_wr(ADDR_ALARM_WDAY_DATE, 8'h15);
        bus_wr(ADDR_IRQ_CONTROL, 8'h08);
        alarm_try('{7'h30, 6'h12, 3'd0, 6'h15}, 1'b1, 1'b1);
        alarm_try('{7'h30, 6'h12, 3'd0, 6'h14}, 1'b0, 1'b0);
        bus_wr(ADDR_IRQ_CONTROL, 8'h00);
        bus_wr(ADDR_ALARM_MINUTE, 8'h80);
        bus_wr(ADDR_ALARM_HOUR, 8'h80);
        bus_wr(ADDR_ALARM_WDAY_DATE, 8'h80);
        alarm_try('{7'h07, 6'h03, 3'd2, 6'h09}, 1'b1, 1'b0);
        bus_wr(ADDR_IRQ_CONTROL, 8'h08);
        alarm_try('{7'h59, 6'h23, 3'd6, 6'h31}, 1'b1, 1'b1);
        bus_wr(ADDR_IRQ_CONTROL, 8'h48);
        alarm_try('{7'h30, 6'h12, 3'd1, 6'h15}, 1'b0, 1'b0);
        summarize();
    end
endmodule : test_rtc_alarm_update_interrupt

// ---- core/rtcai_core.sv ----
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
// Notes on behaviour
// - Update event on second or minute boundary.
// - Update event sets update flag until cleared.
// - Update event drives pin only when enabled.
// - Update low pulse lasts fixed interval, self-releases.
// - Clearing update flag keeps pin state.
// - Dropping update enable releases pin at once.
// - Alarm sets flag, pin low within limit.
// - Alarm low level has no timeout.
// - No alarm events while clock stopped.
// - Matching alarm sets flag, drives if enabled.
// - Select bit picks weekday or date meaning.
// - Weekday mode: one bit per weekday.
// - Field mask bit high ignores that field.
// - All masks high: alarm every minute.
// - Alarm flag holds until zero written.
// - Writing one ignored; zero clears, releases pin.
module rtcai_core
    import rtcai_pkg::*;
#(
    parameter int P_PULSE_CYC = rtcai_pkg::PULSE_MIN_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Time base
    input wire rtcai_pkg::rtcai_time_t i_time,
    input wire logic i_sec_tick,
    input wire logic i_min_tick,
    // Register port
    input wire rtcai_pkg::rtcai_bus_t i_bus,
    output logic [7:0] o_rdata,
    // Interrupt pin, active low, open drain
    output logic o_irq_n_out,
    output logic o_irq_n_oe,
    // Level interrupt toward the system
    output logic o_irq
);
    import rtcai_pkg::*;

    // ----------------------------------------------------------------
    // How the block works
    // ----------------------------------------------------------------

    // Two sources share one open-drain line.
    // The update source follows the time base.
    // It fires on a second or a minute tick.
    // The extension byte picks which tick counts.
    // Each update event sets a sticky flag.
    // With the update enable high it also loads the pulse counter.
    // The line then stays low for a fixed time.
    // After that the line lets go by itself.
    // A new event reloads the counter at once.
    // So close events stretch the low time.

    // The alarm source compares fields once a minute.
    // Minute, hour and day are compared.
    // Each field has a mask bit at the top.
    // A high mask bit drops the field out.
    // The day byte is a bitmap or a date.
    // The select bit in the extension byte decides.
    // A match sets the alarm flag.
    // With its enable high it holds the line low.
    // Only a written zero or a dropped enable ends it.

    // The clock stop bit blocks alarm events.
    // It does not block update events.
    // The update side keeps running on purpose.

    // Flags clear only on a written zero.
    // A written one leaves the flag as it was.
    // An event in the same cycle as a clear wins.
    // Losing an event is worse than a late clear.

    // The status and mask pair is a second view.
    // It feeds the level interrupt toward the system.
    // Status bits clear by writing ones.
    // The mask does not affect the open-drain line.

    // Software should turn the alarm enable off first.
    // Changing alarm bytes with it on may fire early.
    // The logic does not guard against that case.
    // Doing so would hide a real match as well.

    // Alarm bytes may serve as plain storage.
    // The alarm enable must then stay off.
    // Otherwise stored values could drive the line.

    // Weekday codes above six pick bit seven.
    // Bit seven is the mask, so avoid such codes.
    // The time base never presents them.

    // Read data stand for one cycle only.
    // All other cycles show zero on the port.
    // That keeps a stale byte from being taken twice.

    // The pulse width is a parameter.
    // Its default meets the least documented time.
    // A short value keeps simulation quick.

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // A field takes part unless its active-high mask bit is high.
    function automatic logic field_ok(input logic msk, input logic [6:0] a, input logic [6:0] b);
        field_ok = msk | (a == b);
    endfunction : field_ok

    // A flag clears on a write of zero to its bit; a one is ignored.
    function automatic logic clr_zero(input logic wr, input logic bitv);
        clr_zero = wr & ~bitv;
    endfunction : clr_zero

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rtcai_state_t st_q; // Registered state.
    rtcai_state_t st_d; // Next state.
    logic upd_ev; // Time update event this cycle.
    logic alm_ev; // Alarm event this cycle.
    logic day_ok; // Weekday or date part agrees.
    logic alm_match; // All enabled fields agree.
    logic wr_flags; // Write to the flag byte.

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------

    // The select bit picks which boundary counts; low picks seconds.
    assign upd_ev = st_q.ext[BIT_UPD_SEL] ? i_min_tick : i_sec_tick;

    // The shared byte is a weekday bitmap or a two-digit date.
    always_comb begin
        if (st_q.alm_wd[BIT_FIELD_MASK]) begin
            day_ok = 1'b1;
        end else if (st_q.ext[BIT_WDAY_DATE_SEL]) begin
            day_ok = (st_q.alm_wd[5:0] == i_time.date);
        end else begin
            day_ok = st_q.alm_wd[i_time.weekday];
        end
    end

    // With every mask high each field passes, so each minute matches.
    assign alm_match = field_ok(st_q.alm_min[BIT_FIELD_MASK], st_q.alm_min[6:0], i_time.minute)
        & field_ok(st_q.alm_hour[BIT_FIELD_MASK], {1'b0, st_q.alm_hour[5:0]}, {1'b0, i_time.hour})
        & day_ok;

    // Alarms are judged once per minute and never while stopped.
    assign alm_ev = i_min_tick & alm_match & ~st_q.ctl[BIT_CLOCK_STOP];

    assign wr_flags = i_bus.wr && (i_bus.addr == ADDR_EVENT_FLAGS);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Writes are applied first and events after, so a set wins over a
    // clear landing in the same cycle.
    always_comb begin
        st_d = st_q;
        st_d.rdata = RST_BYTE;
        // Register writes.
        if (i_bus.wr) begin
            if (i_bus.addr == ADDR_ALARM_MINUTE) begin
                st_d.alm_min = i_bus.wdata;
            end else if (i_bus.addr == ADDR_ALARM_HOUR) begin
                st_d.alm_hour = i_bus.wdata;
            end else if (i_bus.addr == ADDR_ALARM_WDAY_DATE) begin
                st_d.alm_wd = i_bus.wdata;
            end else if (i_bus.addr == ADDR_EXT_CONTROL) begin
                st_d.ext = i_bus.wdata;
            end else if (i_bus.addr == ADDR_IRQ_CONTROL) begin
                st_d.ctl = i_bus.wdata;
            end else if (i_bus.addr == ADDR_IRQ_STATUS) begin
                st_d.irq_sts = st_q.irq_sts & ~i_bus.wdata[STS_W-1:0];
            end else if (i_bus.addr == ADDR_IRQ_MASK) begin
                st_d.irq_msk = i_bus.wdata[STS_W-1:0];
            end
        end
        // Flags clear only on a written zero.
        if (clr_zero(wr_flags, i_bus.wdata[BIT_UPDATE_FLAG])) begin
            st_d.update_flag = 1'b0;
        end
        if (clr_zero(wr_flags, i_bus.wdata[BIT_ALARM_FLAG])) begin
            st_d.alarm_flag = 1'b0;
            st_d.alm_drv = 1'b0;
        end
        // Alarm enable low cancels a held alarm level.
        if (!st_d.ctl[BIT_ALM_IRQ_EN]) begin
            st_d.alm_drv = 1'b0;
        end
        // Update pulse timing; the flag plays no part in it.
        if (st_q.upd_drv) begin
            if (st_q.pulse_cnt == CNT_ZERO) begin
                st_d.upd_drv = 1'b0;
            end else begin
                st_d.pulse_cnt = st_q.pulse_cnt - CNT_ONE;
            end
        end
        // Update event.
        if (upd_ev) begin
            st_d.update_flag = 1'b1;
            st_d.irq_sts[STS_UPDATE] = 1'b1;
            if (st_d.ctl[BIT_UPD_IRQ_EN]) begin
                st_d.upd_drv = 1'b1;
                st_d.pulse_cnt = CNT_W'(P_PULSE_CYC - 1);
            end
        end
        // Dropping the enable releases the pulse at once.
        if (!st_d.ctl[BIT_UPD_IRQ_EN]) begin
            st_d.upd_drv = 1'b0;
        end
        // Alarm event; the level then holds with no timeout.
        if (alm_ev) begin
            st_d.alarm_flag = 1'b1;
            st_d.irq_sts[STS_ALARM] = 1'b1;
            if (st_d.ctl[BIT_ALM_IRQ_EN]) begin
                st_d.alm_drv = 1'b1;
            end
        end
        // The pin is pulled low while either source asks for it.
        st_d.pin_oe = st_d.upd_drv | st_d.alm_drv;
        st_d.irq = |(st_d.irq_sts & st_d.irq_msk);
        // Register reads; unmapped bytes and unused flag bits read zero.
        if (i_bus.rd) begin
            if (i_bus.addr == ADDR_ALARM_MINUTE) begin
                st_d.rdata = st_q.alm_min;
            end else if (i_bus.addr == ADDR_ALARM_HOUR) begin
                st_d.rdata = st_q.alm_hour;
            end else if (i_bus.addr == ADDR_ALARM_WDAY_DATE) begin
                st_d.rdata = st_q.alm_wd;
            end else if (i_bus.addr == ADDR_EXT_CONTROL) begin
                st_d.rdata = st_q.ext;
            end else if (i_bus.addr == ADDR_EVENT_FLAGS) begin
                st_d.rdata[BIT_UPDATE_FLAG] = st_q.update_flag;
                st_d.rdata[BIT_ALARM_FLAG] = st_q.alarm_flag;
            end else if (i_bus.addr == ADDR_IRQ_CONTROL) begin
                st_d.rdata = st_q.ctl;
            end else if (i_bus.addr == ADDR_IRQ_STATUS) begin
                st_d.rdata[STS_W-1:0] = st_q.irq_sts;
            end else if (i_bus.addr == ADDR_IRQ_MASK) begin
                st_d.rdata[STS_W-1:0] = st_q.irq_msk;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // Everything resets to zero: enables off, pin released.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // The pin only ever drives low, so its data stays at the reset zero.
    // The pin data bit is never written after reset.
    // It is kept in the state so the port comes from a flop.
    assign o_irq_n_out = st_q.pin_out;
    assign o_irq_n_oe = st_q.pin_oe;
    assign o_irq = st_q.irq;
    assign o_rdata = st_q.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    upd_boundary_a: assert property (st_q.ext[BIT_UPD_SEL] && i_min_tick |=> st_q.update_flag)
        else $error("minute boundary did not raise update flag");
    upd_flag_hold_a: assert property (st_q.update_flag && !wr_flags |=> st_q.update_flag)
        else $error("update flag lost without a clear");
    upd_pin_gate_a: assert property (upd_ev && !st_d.ctl[BIT_UPD_IRQ_EN] && !st_q.alm_drv
        && !alm_ev |=> !o_irq_n_oe)
        else $error("pin driven with update enable low");
    upd_pulse_len_a: assert property (st_q.upd_drv && st_q.pulse_cnt != CNT_ZERO
        && st_d.ctl[BIT_UPD_IRQ_EN] |=> st_q.upd_drv && o_irq_n_oe)
        else $error("update pulse ended early");
    upd_pulse_end_a: assert property (st_q.upd_drv && st_q.pulse_cnt == CNT_ZERO && !upd_ev
        |=> !st_q.upd_drv)
        else $error("update pulse did not release");
    uf_clear_keep_a: assert property (wr_flags && st_q.upd_drv && st_q.pulse_cnt != CNT_ZERO
        && st_d.ctl[BIT_UPD_IRQ_EN] |=> o_irq_n_oe)
        else $error("flag clear changed the pin");
    uie_release_a: assert property (st_q.upd_drv && !st_d.ctl[BIT_UPD_IRQ_EN]
        && !st_d.alm_drv |=> !o_irq_n_oe)
        else $error("enable drop did not release pin");
    alarm_set_a: assert property (alm_ev |=> st_q.alarm_flag && st_q.irq_sts[STS_ALARM])
        else $error("alarm event did not set flag");
    alarm_hold_a: assert property (st_q.alm_drv && !wr_flags && st_d.ctl[BIT_ALM_IRQ_EN]
        |=> st_q.alm_drv && o_irq_n_oe)
        else $error("alarm level timed out");
    stop_no_alarm_a: assert property (st_q.ctl[BIT_CLOCK_STOP] |-> !alm_ev)
        else $error("alarm while clock stopped");
    alarm_drive_a: assert property (alm_ev && st_d.ctl[BIT_ALM_IRQ_EN] |=> o_irq_n_oe)
        else $error("enabled alarm did not drive pin");
    weekday_pick_a: assert property (!st_q.alm_wd[BIT_FIELD_MASK] && !st_q.ext[BIT_WDAY_DATE_SEL]
        |-> day_ok == st_q.alm_wd[i_time.weekday])
        else $error("weekday bitmap mismatch");
    all_masked_a: assert property (i_min_tick && !st_q.ctl[BIT_CLOCK_STOP] && st_q.alm_min[BIT_FIELD_MASK]
        && st_q.alm_hour[BIT_FIELD_MASK] && st_q.alm_wd[BIT_FIELD_MASK] |-> alm_ev)
        else $error("fully masked alarm missed a minute");
    af_one_ignored_a: assert property (wr_flags && i_bus.wdata[BIT_ALARM_FLAG] && !st_q.alarm_flag
        && !alm_ev |=> !st_q.alarm_flag)
        else $error("writing one set the alarm flag");
    af_clear_rel_a: assert property (wr_flags && !i_bus.wdata[BIT_ALARM_FLAG] && !alm_ev
        |=> !st_q.alarm_flag && !st_q.alm_drv)
        else $error("alarm clear did not release");
    pin_or_a: assert property (o_irq_n_oe == (st_q.upd_drv || st_q.alm_drv) && !o_irq_n_out)
        else $error("pin not the or of sources");

    // ----------------------------------------------------------------
    // Further checks
    // ----------------------------------------------------------------

    // Every update event must set both views of the flag.
    upd_sets_flag_a: assert property (upd_ev |=> st_q.update_flag && st_q.irq_sts[STS_UPDATE])
        else $error("update event did not set flag");

    // An enabled event must load the full pulse length.
    pulse_load_a: assert property (upd_ev && st_d.ctl[BIT_UPD_IRQ_EN] |=> st_q.pulse_cnt == CNT_W'(P_PULSE_CYC - 1))
        else $error("pulse counter not loaded");

    // In date mode the day part is the date compare.
    date_pick_a: assert property (!st_q.alm_wd[BIT_FIELD_MASK] && st_q.ext[BIT_WDAY_DATE_SEL]
        |-> day_ok == (st_q.alm_wd[5:0] == i_time.date))
        else $error("date compare mismatch");

    // Alarms are only judged on a minute tick.
    alarm_tick_only_a: assert property (!i_min_tick |-> !alm_ev)
        else $error("alarm away from minute tick");

    // Read data must fall back to zero after a read.
    rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == RST_BYTE)
        else $error("read data not idle");

    // Note that these checks watch state and outputs.
    // They assume the time base gives legal codes.
    // A weekday above six is outside their scope.

endmodule : rtcai_core

// ---- core/rtcai_pkg.sv ----
package rtcai_pkg;

    // ----------------------------------------------------------------
    // Register map, one byte per address
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ALARM_MINUTE = 8'h17;
    localparam logic [7:0] ADDR_ALARM_HOUR = 8'h18;
    localparam logic [7:0] ADDR_ALARM_WDAY_DATE = 8'h19;
    localparam logic [7:0] ADDR_EXT_CONTROL = 8'h1C;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h1D;
    localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h1E;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_FIELD_MASK = 7;
    localparam int BIT_UPD_SEL = 5;
    localparam int BIT_WDAY_DATE_SEL = 3;
    localparam int BIT_UPDATE_FLAG = 5;
    localparam int BIT_ALARM_FLAG = 3;
    localparam int BIT_CLOCK_STOP = 6;
    localparam int BIT_UPD_IRQ_EN = 5;
    localparam int BIT_ALM_IRQ_EN = 3;
    localparam int STS_UPDATE = 0;
    localparam int STS_ALARM = 1;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int REG_W = 8;
    localparam int STS_W = 2;
    localparam int CNT_W = 21;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_STS = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;

    // ----------------------------------------------------------------
    // Timing: clock period and the two documented times
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint PULSE_MIN_PS = 64'd7570000000;
    localparam longint ALARM_MAX_PS = 64'd1460000000;
    // Least time rounds up, longest time rounds down.
    localparam int PULSE_MIN_CYC = int'((PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int ALARM_MAX_CYC = int'(ALARM_MAX_PS / CLK_PERIOD_PS);

    // Current calendar time from the clock counters.
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [2:0] weekday;
        logic [5:0] date;
    } rtcai_time_t;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtcai_bus_t;

    // Whole state of the block.
    typedef struct packed {
        logic [7:0] alm_min;
        logic [7:0] alm_hour;
        logic [7:0] alm_wd;
        logic [7:0] ext;
        logic [7:0] ctl;
        logic update_flag;
        logic alarm_flag;
        logic upd_drv;
        logic alm_drv;
        logic [CNT_W-1:0] pulse_cnt;
        logic [STS_W-1:0] irq_sts;
        logic [STS_W-1:0] irq_msk;
        logic irq;
        logic pin_oe;
        logic pin_out;
        logic [7:0] rdata;
    } rtcai_state_t;

endpackage : rtcai_pkg
